// ---- srk_pkg.sv ----
/*
  Shared constants for the socket receive-pointer / keep-alive register slice.
  Assumes a single 250 MHz clock and byte-wide register access.
*/
// ==========================================================================
// Package
// ==========================================================================
package srk_pkg;
  // Register byte offsets (MSB at the lower address)
  localparam logic [7:0] OFF_RSR_HI   = 8'h26;
  localparam logic [7:0] OFF_RSR_LO   = 8'h27;
  localparam logic [7:0] OFF_RD_HI    = 8'h28;
  localparam logic [7:0] OFF_RD_LO    = 8'h29;
  localparam logic [7:0] OFF_WR_HI    = 8'h2a;
  localparam logic [7:0] OFF_WR_LO    = 8'h2b;
  localparam logic [7:0] OFF_IMR      = 8'h2c;
  localparam logic [7:0] OFF_FRAG_HI  = 8'h2d;
  localparam logic [7:0] OFF_FRAG_LO  = 8'h2e;
  localparam logic [7:0] OFF_KPALV    = 8'h2f;
  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_CMD      = 8'h01;
  localparam logic [7:0] OFF_IRQ      = 8'h02;
  localparam logic [7:0] OFF_STATE    = 8'h03;
  localparam logic [7:0] OFF_SUMMARY  = 8'h04;
  localparam logic [7:0] OFF_RXBUF    = 8'h1e;
  // Reset values
  localparam logic [15:0] RST_PTR     = 16'h0000;
  localparam logic [7:0]  RST_IMR     = 8'hff;
  localparam logic [15:0] RST_FRAG    = 16'h4000;
  localparam logic [7:0]  RST_KPALV   = 8'h00;
  localparam logic [7:0]  RST_RXBUF   = 8'h02;
  // Field layout
  localparam int IRQ_SEND_OK = 4;
  localparam int IRQ_TIMEOUT = 3;
  localparam int IRQ_RECEIVE_DONE_CMD    = 2;
  localparam int IRQ_PEER_CLOSED_FLAG  = 1;
  localparam int IRQ_CON     = 0;
  localparam logic [7:0] IRQ_VALID   = 8'h1f;
  localparam logic [3:0] PROTO_TCP   = 4'h1;
  // Commands
  localparam logic [7:0] CMD_OPEN    = 8'h01;
  localparam logic [7:0] CMD_RECEIVE_DONE_CMD    = 8'h40;
  localparam logic [7:0] CMD_KEEP    = 8'h22;
  // Socket states
  localparam logic [7:0] ST_CLOSED   = 8'h00;
  localparam logic [7:0] ST_CONN     = 8'h17;
  // Timing
  localparam longint CLK_HZ          = 250000000;
  localparam longint KA_UNIT_S       = 5;
  localparam longint KA_UNIT_CYC     = CLK_HZ * KA_UNIT_S;
  localparam int     HOST_RD_TRIES   = 3;
endpackage

// ---- srk_if.sv ----
/*
  Byte register link between host controller and socket register slice.
  Assumes both ends share ref_clk; reads answer one cycle after the strobe.
*/
// ==========================================================================
// Interface
// ==========================================================================
interface srk_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       host_irq_pin_low_n;
  modport device (input addr, input wdata, input wr, input rd, output rdata, output host_irq_pin_low_n);
  modport host   (output addr, output wdata, output wr, output rd, input rdata, input host_irq_pin_low_n);
endinterface

// ---- srk_ka_timer.sv ----
/*
  Keep-alive period timer: prescaled 5 s ticks, counted against a period.
  Assumes the enclosing slice gates it with TCP mode and connection state.
*/
// ==========================================================================
// Keep-alive timer
// ==========================================================================
module srk_ka_timer #(
  parameter longint UNIT_CYC = srk_pkg::KA_UNIT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [7:0] period,
  input  wire logic       restart,
  output logic            fire
);
  logic [31:0] pre;
  logic [7:0]  units;
  logic        tick;

  assign tick = (pre == 32'(UNIT_CYC - 1));

  // Prescaler to the 5 s unit, restarted after each probe
  always_ff @(posedge ref_clk) begin
    if (reset || !run || restart || tick) begin
      pre <= 32'h0000_0000;
    end else begin
      pre <= pre + 32'h0000_0001;
    end
  end

  // Unit counter; fires a one-cycle pulse when period elapses
  always_ff @(posedge ref_clk) begin
    if (reset || !run || restart) begin
      units <= 8'h00;
      fire  <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (tick) begin
        if (units + 8'h01 >= period) begin
          units <= 8'h00;
          fire  <= 1'b1;
        end else begin
          units <= units + 8'h01;
        end
      end
    end
  end
endmodule // srk_ka_timer

// ---- srk_device.sv ----
/*
  Socket register slice: receive pointers, interrupt mask, fragment field,
  keep-alive. Assumes a byte register port and event inputs from the engine.
*/
// Implementation choice: the address-and-strobe port.
module srk_device #(
  parameter longint KA_UNIT_CYC = srk_pkg::KA_UNIT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  srk_if.device            bus,
  input  wire logic        rx_store,
  input  wire logic [15:0] rx_store_len,
  input  wire logic        ev_send_ok,
  input  wire logic        ev_timeout,
  input  wire logic        ev_peer_closed_flag,
  input  wire logic        ev_con,
  input  wire logic        data_moved,
  input  wire logic [7:0]  socket_state,
  output logic [15:0]      ip_fragment_field,
  output logic [15:0]      rx_freed_ptr,
  output logic             liveness_probe_packet
);
  logic [15:0] rx_read_pointer;
  logic [15:0] rx_write_pointer;
  logic [15:0] rx_received_size;
  logic [7:0]  socket_irq_mask;
  logic [7:0]  socket_irq_flags;
  logic [7:0]  keepalive_period;
  logic [7:0]  socket_mode_reg;
  logic [7:0]  rx_buffer_size;
  logic        socket_irq_summary;
  logic        traffic_seen;
  logic        is_tcp;
  logic        ka_run;
  logic        ka_fire;
  logic        cmd_wr;
  logic        do_open;
  logic        do_receive_done_cmd;
  logic        do_keep;
  logic        manual_probe;
  logic [7:0]  ev_vec;
  logic [7:0]  next_flags;

  // ========================================================================
  // Command decode
  // ========================================================================
  assign cmd_wr  = bus.wr && (bus.addr == srk_pkg::OFF_CMD);
  assign do_open = cmd_wr && (bus.wdata == srk_pkg::CMD_OPEN);
  assign do_receive_done_cmd = cmd_wr && (bus.wdata == srk_pkg::CMD_RECEIVE_DONE_CMD);
  assign do_keep = cmd_wr && (bus.wdata == srk_pkg::CMD_KEEP);
  assign is_tcp  = (socket_mode_reg[3:0] == srk_pkg::PROTO_TCP);

  // ========================================================================
  // Receive pointers
  // ========================================================================
  // Size is a modulo-65536 difference of the pointers
  assign rx_received_size = rx_write_pointer - rx_read_pointer;

  // Read pointer: host writes bytes, open clears it
  always_ff @(posedge ref_clk) begin
    if (reset || do_open) begin
      rx_read_pointer <= srk_pkg::RST_PTR;
    end else if (bus.wr && bus.addr == srk_pkg::OFF_RD_HI) begin
      rx_read_pointer[15:8] <= bus.wdata;
    end else if (bus.wr && bus.addr == srk_pkg::OFF_RD_LO) begin
      rx_read_pointer[7:0] <= bus.wdata;
    end
  end

  // Write pointer advances on stored data, carry dropped
  always_ff @(posedge ref_clk) begin
    if (reset || do_open) begin
      rx_write_pointer <= srk_pkg::RST_PTR;
    end else if (rx_store) begin
      rx_write_pointer <= rx_write_pointer + rx_store_len;
    end
  end

  // Freed-space boundary follows the read pointer only on receive-done
  always_ff @(posedge ref_clk) begin
    if (reset || do_open) begin
      rx_freed_ptr <= srk_pkg::RST_PTR;
    end else if (do_receive_done_cmd) begin
      rx_freed_ptr <= rx_read_pointer;
    end
  end

  // ========================================================================
  // Configuration registers
  // ========================================================================
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      socket_irq_mask   <= srk_pkg::RST_IMR;
      ip_fragment_field <= srk_pkg::RST_FRAG;
      keepalive_period  <= srk_pkg::RST_KPALV;
      socket_mode_reg   <= 8'h00;
      rx_buffer_size    <= srk_pkg::RST_RXBUF;
    end else if (bus.wr) begin
      unique case (bus.addr)
        srk_pkg::OFF_IMR:     socket_irq_mask <= bus.wdata & srk_pkg::IRQ_VALID;
        srk_pkg::OFF_FRAG_HI: ip_fragment_field[15:8] <= bus.wdata;
        srk_pkg::OFF_FRAG_LO: ip_fragment_field[7:0] <= bus.wdata;
        srk_pkg::OFF_KPALV:   keepalive_period <= bus.wdata;
        srk_pkg::OFF_MODE:    socket_mode_reg <= bus.wdata;
        srk_pkg::OFF_RXBUF:   rx_buffer_size <= bus.wdata;
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Interrupt flags
  // ========================================================================
  // Event vector in flag bit order
  always_comb begin
    ev_vec = 8'h00;
    ev_vec[srk_pkg::IRQ_SEND_OK] = ev_send_ok;
    ev_vec[srk_pkg::IRQ_TIMEOUT] = ev_timeout;
    ev_vec[srk_pkg::IRQ_RECEIVE_DONE_CMD]    = rx_store;
    ev_vec[srk_pkg::IRQ_PEER_CLOSED_FLAG]  = ev_peer_closed_flag;
    ev_vec[srk_pkg::IRQ_CON]     = ev_con;
    next_flags = socket_irq_flags;
    if (bus.wr && bus.addr == srk_pkg::OFF_IRQ) begin
      next_flags = next_flags & ~bus.wdata; // Write one to clear
    end
    next_flags = next_flags | (ev_vec & socket_irq_mask); // set wins
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      socket_irq_flags <= 8'h00;
    end else begin
      socket_irq_flags <= next_flags & srk_pkg::IRQ_VALID;
    end
  end

  // Summary bit and active-low host pin
  assign socket_irq_summary = |socket_irq_flags;
  assign bus.host_irq_pin_low_n = ~(|(socket_irq_mask & socket_irq_flags) & socket_irq_summary);

  // ========================================================================
  // Keep-alive
  // ========================================================================
  // Data seen since connection established
  always_ff @(posedge ref_clk) begin
    if (reset || do_open || socket_state != srk_pkg::ST_CONN) begin
      traffic_seen <= 1'b0;
    end else if (data_moved) begin
      traffic_seen <= 1'b1;
    end
  end

  assign ka_run = is_tcp && traffic_seen && (keepalive_period != 8'h00);

  // Manual probe is taken only with the automatic period at zero
  assign manual_probe = do_keep && (keepalive_period == 8'h00) && is_tcp && traffic_seen;

  srk_ka_timer #(.UNIT_CYC(KA_UNIT_CYC)) u_ka (
    .ref_clk (ref_clk),
    .reset   (reset),
    .run     (ka_run),
    .period  (keepalive_period),
    .restart (manual_probe), // automatic probes restart at the timer's own wrap
    .fire    (ka_fire)
  );

  // Probe pulse: automatic or manual (manual only when period is zero)
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      liveness_probe_packet <= 1'b0;
    end else begin
      liveness_probe_packet <= ka_fire || manual_probe;
    end
  end

  // ========================================================================
  // Read data
  // ========================================================================
  always_ff @(posedge ref_clk) begin
    if (reset || !bus.rd) begin
      bus.rdata <= 8'h00;
    end else begin
      unique case (bus.addr)
        srk_pkg::OFF_RSR_HI:  bus.rdata <= rx_received_size[15:8];
        srk_pkg::OFF_RSR_LO:  bus.rdata <= rx_received_size[7:0];
        srk_pkg::OFF_RD_HI:   bus.rdata <= rx_read_pointer[15:8];
        srk_pkg::OFF_RD_LO:   bus.rdata <= rx_read_pointer[7:0];
        srk_pkg::OFF_WR_HI:   bus.rdata <= rx_write_pointer[15:8];
        srk_pkg::OFF_WR_LO:   bus.rdata <= rx_write_pointer[7:0];
        srk_pkg::OFF_IMR:     bus.rdata <= socket_irq_mask;
        srk_pkg::OFF_FRAG_HI: bus.rdata <= ip_fragment_field[15:8];
        srk_pkg::OFF_FRAG_LO: bus.rdata <= ip_fragment_field[7:0];
        srk_pkg::OFF_KPALV:   bus.rdata <= keepalive_period;
        srk_pkg::OFF_MODE:    bus.rdata <= socket_mode_reg;
        srk_pkg::OFF_IRQ:     bus.rdata <= socket_irq_flags;
        srk_pkg::OFF_STATE:   bus.rdata <= socket_state;
        srk_pkg::OFF_SUMMARY: bus.rdata <= {7'h00, socket_irq_summary};
        srk_pkg::OFF_RXBUF:   bus.rdata <= rx_buffer_size;
        default:              bus.rdata <= 8'h00;
      endcase
    end
  end
endmodule // srk_device

// ---- srk_host.sv ----
/*
  Host-side controller: reads a stable received size, consumes it by
  advancing the read pointer, then issues receive-done.
  Assumes the device answers reads one cycle after the strobe.
*/
// ==========================================================================
// Host end
// ==========================================================================
module srk_host (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  srk_if.host              bus,
  input  wire logic        consume_req,
  input  wire logic [15:0] consume_len,
  output logic             consume_busy,
  output logic             consume_done,
  output logic [15:0]      rx_avail,
  output logic [15:0]      rx_start,
  output logic             irq_seen
);
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000, S_SZ_H = 4'b0001, S_SZ_L = 4'b0010, S_SZ_CHK = 4'b0011,
    S_RD_H  = 4'b0100, S_RD_L = 4'b0101, S_RD_W = 4'b0110,
    S_WR_H  = 4'b0111, S_WR_L = 4'b1000, S_CMD  = 4'b1001, S_DONE = 4'b1010
  } srk_host_e;
  srk_host_e   state;
  logic [15:0] sample;
  logic [15:0] prev;
  logic        have_prev;
  logic [15:0] len;

  assign consume_busy = (state != S_IDLE);
  assign irq_seen     = ~bus.host_irq_pin_low_n;

  // Sequencer with bus strobes issued from flops
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= S_IDLE; bus.wr <= 1'b0; bus.rd <= 1'b0;
      bus.addr <= 8'h00; bus.wdata <= 8'h00; sample <= 16'h0000; prev <= 16'h0000;
      have_prev <= 1'b0; len <= 16'h0000; rx_avail <= 16'h0000; rx_start <= 16'h0000;
      consume_done <= 1'b0;
    end else begin
      bus.wr <= 1'b0; bus.rd <= 1'b0; consume_done <= 1'b0;
      unique case (state)
        S_IDLE: if (consume_req) begin
          len <= consume_len; have_prev <= 1'b0;
          bus.rd <= 1'b1; bus.addr <= srk_pkg::OFF_RSR_HI; state <= S_SZ_H;
        end
        S_SZ_H: begin
          bus.rd <= 1'b1; bus.addr <= srk_pkg::OFF_RSR_LO; state <= S_SZ_L;
        end
        S_SZ_L: begin
          sample[15:8] <= bus.rdata; state <= S_SZ_CHK;
        end
        S_SZ_CHK: begin
          if (have_prev && prev == {sample[15:8], bus.rdata}) begin
            rx_avail <= prev; bus.rd <= 1'b1; bus.addr <= srk_pkg::OFF_RD_HI; state <= S_RD_H;
          end else begin
            prev <= {sample[15:8], bus.rdata}; have_prev <= 1'b1;
            bus.rd <= 1'b1; bus.addr <= srk_pkg::OFF_RSR_HI; state <= S_SZ_H;
          end
        end
        S_RD_H: begin
          bus.rd <= 1'b1; bus.addr <= srk_pkg::OFF_RD_LO; state <= S_RD_L;
        end
        S_RD_L: begin
          sample[15:8] <= bus.rdata; state <= S_RD_W;
        end
        S_RD_W: begin
          rx_start <= {sample[15:8], bus.rdata};
          if (len > rx_avail) len <= rx_avail;
          sample <= {sample[15:8], bus.rdata};
          state <= S_WR_H;
        end
        S_WR_H: begin
          sample <= sample + len; // carry dropped
          state <= S_WR_L;
        end
        S_WR_L: begin
          bus.wr <= 1'b1; bus.addr <= srk_pkg::OFF_RD_HI; bus.wdata <= sample[15:8]; state <= S_CMD;
        end
        S_CMD: begin
          bus.wr <= 1'b1; bus.addr <= srk_pkg::OFF_RD_LO; bus.wdata <= sample[7:0]; state <= S_DONE;
        end
        S_DONE: begin
          bus.wr <= 1'b1; bus.addr <= srk_pkg::OFF_CMD; bus.wdata <= srk_pkg::CMD_RECEIVE_DONE_CMD;
          consume_done <= 1'b1; state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // srk_host

// ---- srk_checker.sv ----
/*
  Checker for the host-to-device register link of the socket slice.
  Assumes it is instantiated beside the interface joining the two ends.
*/
// ==========================================================================
// Checker
// ==========================================================================
module srk_checker (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       host_irq_pin_low_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  logic [7:0] sh_hi;
  logic [7:0] sh_lo;
  logic [1:0] sz_cnt;
  logic       lo_done;

  // Shadow of the read pointer as the host wrote it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sh_hi <= 8'h00;
      sh_lo <= 8'h00;
    end else if (wr && addr == srk_pkg::OFF_RD_HI) begin
      sh_hi <= wdata;
    end else if (wr && addr == srk_pkg::OFF_RD_LO) begin
      sh_lo <= wdata;
    end
  end

  // Size reads and pointer update seen since the last command
  always_ff @(posedge ref_clk) begin
    if (reset || (wr && addr == srk_pkg::OFF_CMD)) begin
      sz_cnt  <= 2'h0;
      lo_done <= 1'b0;
    end else begin
      if (rd && addr == srk_pkg::OFF_RSR_LO && sz_cnt != 2'h3) sz_cnt <= sz_cnt + 2'h1;
      if (wr && addr == srk_pkg::OFF_RD_LO) lo_done <= 1'b1;
    end
  end

  strobe_exclusive_a: assert property (!(wr && rd))
    else $error("read and write strobes together");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  ptr_hi_read_a: assert property (rd && addr == srk_pkg::OFF_RD_HI |=> rdata == $past(sh_hi))
    else $error("read pointer high byte differs from written value");
  ptr_lo_read_a: assert property (rd && addr == srk_pkg::OFF_RD_LO |=> rdata == $past(sh_lo))
    else $error("read pointer low byte differs from written value");
  size_reread_a: assert property (wr && addr == srk_pkg::OFF_RD_HI |-> sz_cnt >= 2'h2)
    else $error("pointer written before size was read twice");
  receive_done_cmd_after_ptr_a: assert property (wr && addr == srk_pkg::OFF_CMD |-> lo_done)
    else $error("receive done before pointer update");
  cmd_is_receive_done_cmd_a: assert property (wr && addr == srk_pkg::OFF_CMD |-> wdata == srk_pkg::CMD_RECEIVE_DONE_CMD)
    else $error("host issued an unexpected command");
  irq_hold_a: assert property (!host_irq_pin_low_n && !(wr && (addr == srk_pkg::OFF_IRQ ||
    addr == srk_pkg::OFF_IMR)) |=> !host_irq_pin_low_n)
    else $error("interrupt pin released without a clear");

  cover property (wr && addr == srk_pkg::OFF_CMD);
  cover property (rd && addr == srk_pkg::OFF_RSR_LO ##1 rdata != 8'h00);
  cover property ($fell(host_irq_pin_low_n));
endmodule // srk_checker

// ---- socket_rx_pointer_keepalive_regs_tb_top.sv ----
/*
  Testbench: host and device joined on one link, a second device driven here.
  Assumes the package, interface and both design ends are compiled first.
*/
// ==========================================================================
// Testbench
// ==========================================================================
module socket_rx_pointer_keepalive_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, reset, consume_req, consume_done, consume_busy, irq_seen, probe_b;
  logic [5:0]  ev;
  logic [7:0]  socket_state, rv;
  logic [15:0] rx_store_len, consume_len, rx_avail, rx_start, freed_a, freed_b, frag_b;
  logic [15:0] wa, wb, ra, v, n;
  int          errors, total_checks, cyc, n_probe, n0, last_p, gap;
  logic [7:0]  ra_tab [9] = '{8'h26, 8'h27, 8'h28, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h10};
  logic [7:0]  rx_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h40, 8'h00, 8'h00, 8'h00};

  srk_if bus_a ();
  srk_if bus_b ();
  srk_host u_srk_host (.ref_clk(ref_clk), .reset(reset), .bus(bus_a), .consume_req(consume_req),
    .consume_len(consume_len), .consume_busy(consume_busy), .consume_done(consume_done), .rx_avail(rx_avail),
    .rx_start(rx_start), .irq_seen(irq_seen));
  srk_device #(.KA_UNIT_CYC(10)) u_srk_device (.ref_clk(ref_clk), .reset(reset), .bus(bus_a),
    .rx_store(ev[2]), .rx_store_len(rx_store_len), .ev_send_ok(ev[4]), .ev_timeout(ev[3]),
    .ev_peer_closed_flag(ev[1]), .ev_con(ev[0]), .data_moved(ev[5]), .socket_state(socket_state),
    .ip_fragment_field(), .rx_freed_ptr(freed_a), .liveness_probe_packet());
  srk_device #(.KA_UNIT_CYC(10)) u_srk_device_b (.ref_clk(ref_clk), .reset(reset), .bus(bus_b),
    .rx_store(ev[2]), .rx_store_len(rx_store_len), .ev_send_ok(ev[4]), .ev_timeout(ev[3]),
    .ev_peer_closed_flag(ev[1]), .ev_con(ev[0]), .data_moved(ev[5]), .socket_state(socket_state),
    .ip_fragment_field(frag_b), .rx_freed_ptr(freed_b), .liveness_probe_packet(probe_b));
  srk_checker u_srk_checker (.ref_clk(ref_clk), .reset(reset), .addr(bus_a.addr), .wdata(bus_a.wdata),
    .wr(bus_a.wr), .rd(bus_a.rd), .rdata(bus_a.rdata), .host_irq_pin_low_n(bus_a.host_irq_pin_low_n));

  // Clock and probe spacing monitor
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (probe_b === 1'b1) begin
      n_probe <= n_probe + 1;
      gap <= cyc - last_p;
      last_p <= cyc;
    end
  end

  function automatic logic [15:0] size_exp(input logic [15:0] w, input logic [15:0] r);
    return w - r;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_b.wr <= 1'b1;
    bus_b.addr <= a;
    bus_b.wdata <= d;
    @(posedge ref_clk);
    bus_b.wr <= 1'b0;
  endtask
  task automatic rd_b(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_b.rd <= 1'b1;
    bus_b.addr <= a;
    @(posedge ref_clk);
    bus_b.rd <= 1'b0;
    #1 d = bus_b.rdata;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr_b(a, d[15:8]);
    wr_b(a + 8'h01, d[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] h;
    logic [7:0] l;
    rd_b(a, h);
    rd_b(a + 8'h01, l);
    d = {h, l};
  endtask
  task automatic pulse(input logic [5:0] e, input logic [15:0] len);
    @(posedge ref_clk);
    ev <= e;
    rx_store_len <= len;
    @(posedge ref_clk);
    ev <= 6'h00;
  endtask
  task automatic store(input logic [15:0] len);
    pulse(6'h04, len);
    wa = wa + len;
    wb = wb + len;
  endtask
  task automatic probes(input int cycles, input int exp);
    n0 = n_probe;
    repeat (cycles) @(posedge ref_clk);
    check(16'(n_probe - n0), 16'(exp));
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge ref_clk);
    errors++;
    final_report();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    {bus_b.addr, bus_b.wdata, bus_b.wr, bus_b.rd} = 18'h00000;
    {ev, rx_store_len, consume_req, consume_len} = 39'h0;
    socket_state = srk_pkg::ST_CLOSED;
    {wa, wb, ra} = 48'h0;
    {errors, total_checks, cyc, n_probe, last_p, gap} = '0;
    void'($urandom(32'h7f6df293));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (ra_tab[i]) begin
      rd_b(ra_tab[i], rv);
      check({8'h00, rv}, {8'h00, rx_tab[i]});
    end
    wr_b(srk_pkg::OFF_IMR, 8'hff);
    rd_b(srk_pkg::OFF_IMR, rv);
    check({8'h00, rv}, 16'h001f);
    $display("test reset_values done");
    store(16'hfff0);
    for (int i = 0; i < 8; i++) begin
      store(16'($urandom_range(1, 2048)));
      n = wb - 16'($urandom_range(0, 2048));
      wr16(srk_pkg::OFF_RD_HI, n);
      rd16(srk_pkg::OFF_WR_HI, v);
      check(v, wb);
      rd16(srk_pkg::OFF_RD_HI, v);
      check(v, n);
      rd16(srk_pkg::OFF_RSR_HI, v);
      check(v, size_exp(wb, n));
    end
    wr_b(srk_pkg::OFF_CMD, srk_pkg::CMD_RECEIVE_DONE_CMD);
    @(posedge ref_clk);
    #1 check(freed_b, n);
    wr_b(srk_pkg::OFF_CMD, srk_pkg::CMD_OPEN);
    rd16(srk_pkg::OFF_RD_HI, v);
    check(v, 16'h0000);
    rd16(srk_pkg::OFF_WR_HI, v);
    check(v, 16'h0000);
    wb = 16'h0000;
    $display("test pointers done");
    for (int b = 0; b < 5; b++) begin
      wr_b(srk_pkg::OFF_IRQ, 8'hff);
      wr_b(srk_pkg::OFF_IMR, 8'h1f ^ (8'h01 << b));
      pulse(6'h01 << b, 16'h0000);
      rd_b(srk_pkg::OFF_IRQ, rv);
      check({8'h00, rv}, 16'h0000);
      check({15'h0000, bus_b.host_irq_pin_low_n}, 16'h0001);
      wr_b(srk_pkg::OFF_IMR, 8'h01 << b);
      pulse(6'h01 << b, 16'h0000);
      rd_b(srk_pkg::OFF_IRQ, rv);
      check({8'h00, rv}, 16'h0001 << b);
      check({15'h0000, bus_b.host_irq_pin_low_n}, 16'h0000);
      rd_b(srk_pkg::OFF_SUMMARY, rv);
      check({8'h00, rv}, 16'h0001);
      wr_b(srk_pkg::OFF_IRQ, 8'hff);
      rd_b(srk_pkg::OFF_IRQ, rv);
      check({15'h0000, bus_b.host_irq_pin_low_n}, 16'h0001);
    end
    $display("test interrupts done");
    n = 16'($urandom);
    wr16(srk_pkg::OFF_FRAG_HI, n);
    rd16(srk_pkg::OFF_FRAG_HI, v);
    check(v, n);
    check(frag_b, n);
    $display("test fragment done");
    wr_b(srk_pkg::OFF_MODE, 8'h01);
    wr_b(srk_pkg::OFF_KPALV, 8'h02);
    probes(60, 0);
    socket_state <= srk_pkg::ST_CONN;
    probes(60, 0);
    pulse(6'h20, 16'h0000);
    n0 = n_probe;
    repeat (90) @(posedge ref_clk);
    check({15'h0000, (n_probe - n0) >= 3}, 16'h0001);
    check(16'(gap), 16'h0014);
    wr_b(srk_pkg::OFF_MODE, 8'h02);
    probes(60, 0);
    wr_b(srk_pkg::OFF_KPALV, 8'h00);
    wr_b(srk_pkg::OFF_MODE, 8'h01);
    pulse(6'h20, 16'h0000);
    probes(30, 0);
    wr_b(srk_pkg::OFF_CMD, srk_pkg::CMD_KEEP);
    probes(4, 1);
    wr_b(srk_pkg::OFF_KPALV, 8'hff);
    wr_b(srk_pkg::OFF_CMD, srk_pkg::CMD_KEEP);
    probes(20, 0);
    socket_state <= srk_pkg::ST_CLOSED;
    $display("test keepalive done");
    for (int i = 0; i < 2; i++) begin
      n = (i == 1) ? 16'hffff : 16'($urandom_range(1, 256));
      @(posedge ref_clk);
      consume_req <= 1'b1;
      consume_len <= n;
      @(posedge ref_clk);
      consume_req <= 1'b0;
      #1 check({15'h0000, consume_busy}, 16'h0001);
      repeat (300) begin
        @(posedge ref_clk);
        #1;
        if (consume_done === 1'b1) break;
      end
      check({15'h0000, consume_done}, 16'h0001);
      check({15'h0000, consume_busy}, 16'h0000);
      v = size_exp(wa, ra);
      check(rx_avail, v);
      check(rx_start, ra);
      check({15'h0000, irq_seen}, 16'h0001);
      ra = ra + ((n < v) ? n : v);
      repeat (3) @(posedge ref_clk);
      check(freed_a, ra);
    end
    $display("test host_consume done");
    final_report();
  end
endmodule // socket_rx_pointer_keepalive_regs_tb_top
